// file: rtl/smc_pkg.sv
// package for the per-socket mode register block: offsets, reset values,
// protocol and state codes, timing constants and the shared packed types.
// assumes a 125 MHz core clock and a host port that already framed each access.
package smc_pkg;

  // ----------------------------------------------------------------------
  // register map inside one socket block
  // ----------------------------------------------------------------------
  localparam logic [15:0] SMC_MODE_OFFSET  = 16'h0000;
  localparam logic [15:0] SMC_STATE_OFFSET = 16'h0003;
  localparam logic [7:0]  SMC_MODE_RESET   = 8'h00;
  localparam logic [7:0]  SMC_STATE_RESET  = 8'h00;
  localparam logic [7:0]  SMC_UNMAPPED_READ = 8'h00;
  localparam int          SMC_SOCKETS      = 8;

  // ----------------------------------------------------------------------
  // protocol codes held in the low nibble of the mode register
  // ----------------------------------------------------------------------
  localparam logic [3:0] SMC_PROTO_CLOSED = 4'h0;
  localparam logic [3:0] SMC_PROTO_TCP    = 4'h1;
  localparam logic [3:0] SMC_PROTO_UDP    = 4'h2;
  localparam logic [3:0] SMC_PROTO_RAW    = 4'h4;

  // ----------------------------------------------------------------------
  // socket state codes reached by the open command
  // ----------------------------------------------------------------------
  localparam logic [7:0] SMC_TCP_INITIALISED_STATE = 8'h13;
  localparam logic [7:0] SMC_DATAGRAM_OPEN_STATE   = 8'h22;
  localparam logic [7:0] SMC_RAW_OPEN_STATE        = 8'h42;

  // ----------------------------------------------------------------------
  // timing: the retry time counts in units of 0.1 ms
  // ----------------------------------------------------------------------
  localparam int SMC_CLK_PERIOD_NS      = 8;
  localparam int SMC_RETRY_UNIT_NS      = 100000;
  localparam int SMC_RETRY_UNIT_CYCLES  = (SMC_RETRY_UNIT_NS + SMC_CLK_PERIOD_NS - 1) / SMC_CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  // bit 7, bit 6, bit 5, bit 4, protocol in bits 3..0
  typedef struct packed {
    logic       mac_filter_enable;
    logic       broadcast_block;
    logic       no_delayed_ack;
    logic       single_dest_block;
    logic [3:0] protocol;
  } smc_mode_type;

  // one received packet, already classified by the receive path
  typedef struct packed {
    logic       valid;
    logic [2:0] socket_index;
    logic       broadcast;
    logic       group_dest;
    logic       own_mac;
    logic       ipv6;
  } smc_rx_type;

  typedef enum logic {
    SMC_ACK_IDLE = 1'b0,
    SMC_ACK_WAIT = 1'b1
  } smc_ack_state_type;

endpackage : smc_pkg

// file: rtl/smc_ack_timer.sv
// one socket's acknowledge timer: immediate or delayed ack for tcp data.
// assumes unit_tick pulses once per 0.1 ms and segment_rx is a one-cycle pulse.
`timescale 1ns/10ps
module smc_ack_timer
  import smc_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  // socket mode
  input  wire logic        tcp_mode,
  input  wire logic        no_delayed_ack,
  input  wire logic [15:0] retry_time_value,
  // events
  input  wire logic        unit_tick,
  input  wire logic        segment_rx,
  output logic             ack_send
);

  smc_ack_state_type state_q, state_d;
  logic [16:0]       cnt_q, cnt_d;
  logic              ack_q, ack_d;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    ack_d   = 1'b0;
    case (state_q)
      SMC_ACK_IDLE: begin
        if (tcp_mode && segment_rx) begin
          if (no_delayed_ack) begin
            ack_d = 1'b1;
          end else begin
            // hold ack back
            // one extra unit since the first tick may come at any phase
            state_d = SMC_ACK_WAIT;
            cnt_d   = {1'b0, retry_time_value} + 17'd1;
          end
        end
      end
      SMC_ACK_WAIT: begin
        if (!tcp_mode) begin
          state_d = SMC_ACK_IDLE;
        end else if (segment_rx && no_delayed_ack) begin
          ack_d   = 1'b1;
          state_d = SMC_ACK_IDLE;
        end else if (unit_tick) begin
          cnt_d = cnt_q - 17'd1;
          if (cnt_q <= 17'd1) begin
            ack_d   = 1'b1;
            state_d = SMC_ACK_IDLE;
          end
        end
      end
      default: begin
        state_d = SMC_ACK_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_q <= SMC_ACK_IDLE;
      cnt_q   <= 17'h00000;
      ack_q   <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      ack_q   <= ack_d;
    end
  end

  assign ack_send = ack_q;

endmodule : smc_ack_timer

// file: rtl/smc_socket_mode.sv
// eight socket mode registers with their receive filtering, ack timing,
// igmp version selection and open-command state decode.
// assumes the host serial framing is decoded outside: each access arrives as
// a one-cycle strobe with socket index, offset and data, in the clock domain.
`timescale 1ns/10ps

module smc_socket_mode
  import smc_pkg::*;
#(
  parameter int unsigned RETRY_TICK_CYCLES = SMC_RETRY_UNIT_CYCLES
)
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             clk_en,
  // host register access
  input  wire logic             host_wr_en,
  input  wire logic             host_rd_en,
  input  wire logic [2:0]       host_socket_index,
  input  wire logic [15:0]      host_offset,
  input  wire logic [7:0]       host_wdata,
  output logic [7:0]            host_rdata,
  output logic                  host_rvalid,
  // socket commands
  input  wire logic             cmd_open,
  input  wire logic             cmd_close,
  input  wire logic [2:0]       cmd_socket_index,
  // receive classification
  input  wire smc_rx_type       rx_in,
  output logic                  rx_accept,
  output logic                  rx_drop,
  output logic [2:0]            rx_socket_index,
  // tcp acknowledge timing
  input  wire logic [7:0]       tcp_segment_rx,
  input  wire logic [15:0]      retry_time_value,
  output logic [7:0]            ack_send,
  // per-socket decode
  output logic [7:0]            igmp_version_select,
  output smc_mode_type [7:0]    socket_mode_reg
);

  smc_mode_type [7:0] mode_q, mode_d;
  logic [7:0]         state_q [SMC_SOCKETS];
  logic [7:0]         state_d [SMC_SOCKETS];
  logic [7:0]         rdata_q, rdata_d;
  logic               rvalid_q, rvalid_d;
  logic               accept_q, accept_d;
  logic               drop_q, drop_d;
  logic [2:0]         rx_sock_q, rx_sock_d;
  logic [7:0]         igmp_q, igmp_d;
  logic [15:0]        tick_cnt_q, tick_cnt_d;
  logic               unit_tick;

  // ----------------------------------------------------------------------
  // receive acceptance for one packet against one socket's mode
  // ----------------------------------------------------------------------
  function automatic logic rx_pass(input smc_mode_type m, input smc_rx_type r);
    logic unicast;
    logic pass;
    unicast = !r.broadcast && !r.group_dest;
    pass    = 1'b0;
    case (m.protocol)
      SMC_PROTO_TCP: begin
        pass = unicast;
      end
      SMC_PROTO_UDP: begin
        pass = 1'b1;
        if (r.broadcast && m.broadcast_block) pass = 1'b0;
        if (r.group_dest && !m.mac_filter_enable) pass = 1'b0;
        if (unicast && m.mac_filter_enable && m.single_dest_block) pass = 1'b0;
      end
      SMC_PROTO_RAW: begin
        pass = 1'b1;
        if (m.mac_filter_enable && !(r.broadcast || r.own_mac)) pass = 1'b0;
        if (r.broadcast && m.broadcast_block) pass = 1'b0;
        if (r.group_dest && m.no_delayed_ack) pass = 1'b0;
        if (r.ipv6 && m.single_dest_block) pass = 1'b0;
      end
      default: begin
        // closed or undefined protocol receives nothing
        pass = 1'b0;
      end
    endcase
    return pass;
  endfunction : rx_pass

  // ----------------------------------------------------------------------
  // mode and socket state registers
  // ----------------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    for (int s = 0; s < SMC_SOCKETS; s++) begin
      state_d[s] = state_q[s];
    end
    if (host_wr_en && host_offset == SMC_MODE_OFFSET) begin
      mode_d[host_socket_index] = smc_mode_type'(host_wdata);
    end
    if (cmd_close) begin
      state_d[cmd_socket_index] = SMC_STATE_RESET;
    end else if (cmd_open) begin
      case (mode_q[cmd_socket_index].protocol)
        SMC_PROTO_TCP: state_d[cmd_socket_index] = SMC_TCP_INITIALISED_STATE;
        SMC_PROTO_UDP: state_d[cmd_socket_index] = SMC_DATAGRAM_OPEN_STATE;
        SMC_PROTO_RAW: state_d[cmd_socket_index] = SMC_RAW_OPEN_STATE;
        default:       state_d[cmd_socket_index] = state_q[cmd_socket_index];
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode_q <= {SMC_SOCKETS{SMC_MODE_RESET}};
      for (int s = 0; s < SMC_SOCKETS; s++) begin
        state_q[s] <= SMC_STATE_RESET;
      end
    end else if (clk_en) begin
      mode_q <= mode_d;
      for (int s = 0; s < SMC_SOCKETS; s++) begin
        state_q[s] <= state_d[s];
      end
    end
  end

  // ----------------------------------------------------------------------
  // host read path
  // ----------------------------------------------------------------------
  always_comb begin
    rvalid_d = host_rd_en;
    rdata_d  = rdata_q;
    if (host_rd_en) begin
      if (host_offset == SMC_MODE_OFFSET) begin
        rdata_d = mode_q[host_socket_index];
      end else if (host_offset == SMC_STATE_OFFSET) begin
        rdata_d = state_q[host_socket_index];
      end else begin
        rdata_d = SMC_UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_q  <= SMC_UNMAPPED_READ;
      rvalid_q <= 1'b0;
    end else if (clk_en) begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ----------------------------------------------------------------------
  // receive filter result
  // ----------------------------------------------------------------------
  always_comb begin
    accept_d  = 1'b0;
    drop_d    = 1'b0;
    rx_sock_d = rx_sock_q;
    if (rx_in.valid) begin
      rx_sock_d = rx_in.socket_index;
      accept_d  = rx_pass(mode_q[rx_in.socket_index], rx_in);
      drop_d    = !accept_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      accept_q  <= 1'b0;
      drop_q    <= 1'b0;
      rx_sock_q <= 3'h0;
    end else if (clk_en) begin
      accept_q  <= accept_d;
      drop_q    <= drop_d;
      rx_sock_q <= rx_sock_d;
    end
  end

  // ----------------------------------------------------------------------
  // 0.1 ms tick shared by all ack timers
  // ----------------------------------------------------------------------
  assign unit_tick = (tick_cnt_q == 16'(RETRY_TICK_CYCLES - 1));

  always_comb begin
    tick_cnt_d = unit_tick ? 16'h0000 : tick_cnt_q + 16'h0001;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      tick_cnt_q <= 16'h0000;
    end else if (clk_en) begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // ----------------------------------------------------------------------
  // per-socket ack timers and igmp version decode
  // ----------------------------------------------------------------------
  // a pending delayed ack is not restarted by later segments, so the peer
  // never waits more than one retry time plus one unit
  for (genvar g = 0; g < SMC_SOCKETS; g++) begin : g_sock
    smc_ack_timer smc_ack_timer_inst (
      .clock            (clock),
      .rstn             (rstn),
      .clk_en           (clk_en),
      .tcp_mode         (mode_q[g].protocol == SMC_PROTO_TCP),
      .no_delayed_ack   (mode_q[g].no_delayed_ack),
      .retry_time_value (retry_time_value),
      .unit_tick        (unit_tick),
      .segment_rx       (tcp_segment_rx[g]),
      .ack_send         (ack_send[g])
    );

    assign igmp_d[g] = (mode_q[g].protocol == SMC_PROTO_UDP) && mode_q[g].mac_filter_enable
                       && mode_q[g].no_delayed_ack;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      igmp_q <= 8'h00;
    end else if (clk_en) begin
      igmp_q <= igmp_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign host_rdata          = rdata_q;
  assign host_rvalid         = rvalid_q;
  assign rx_accept           = accept_q;
  assign rx_drop             = drop_q;
  assign rx_socket_index     = rx_sock_q;
  assign igmp_version_select = igmp_q;
  assign socket_mode_reg     = mode_q;

endmodule : smc_socket_mode

// file: tb/smc_socket_mode_properties.sv
// assertions on the ports of the socket mode block.
// assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/10ps
module smc_socket_mode_properties
  import smc_pkg::*;
(
  // clock and reset
  input wire logic               clock,
  input wire logic               rstn,
  input wire logic               clk_en,
  // host access
  input wire logic               host_wr_en,
  input wire logic               host_rd_en,
  input wire logic [2:0]         host_socket_index,
  input wire logic [15:0]        host_offset,
  input wire logic [7:0]         host_wdata,
  input wire logic [7:0]         host_rdata,
  input wire logic               host_rvalid,
  // receive and ack
  input wire smc_rx_type         rx_in,
  input wire logic               rx_accept,
  input wire logic               rx_drop,
  input wire logic [7:0]         tcp_segment_rx,
  input wire logic [7:0]         ack_send,
  input wire smc_mode_type [7:0] socket_mode_reg
);
  logic         wr_q;
  logic         rd_q;
  logic [2:0]   wr_idx_q;
  logic [7:0]   wr_dat_q;
  logic [7:0]   rd_exp_q;
  logic         rxv;
  smc_mode_type m;
  assign rxv = clk_en && rx_in.valid;
  assign m   = socket_mode_reg[rx_in.socket_index];
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------------
  // helpers: remember each mode register access so its effect is judged a cycle later
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    wr_q     <= rstn && clk_en && host_wr_en && host_offset == SMC_MODE_OFFSET;
    rd_q     <= rstn && clk_en && host_rd_en && host_offset == SMC_MODE_OFFSET;
    wr_idx_q <= host_socket_index;
    wr_dat_q <= host_wdata;
    rd_exp_q <= socket_mode_reg[host_socket_index];
  end
  property p_wr; wr_q |-> socket_mode_reg[wr_idx_q] == wr_dat_q; endproperty
  a_wr: assert property (p_wr) else $error("mode write lost");
  property p_rd; rd_q |-> host_rvalid && host_rdata == rd_exp_q; endproperty
  a_rd: assert property (p_rd) else $error("mode read wrong");
  property p_one; rxv |=> rx_accept ^ rx_drop; endproperty
  a_one: assert property (p_one) else $error("no single verdict");
  property p_cl; rxv && m.protocol == SMC_PROTO_CLOSED |=> rx_drop; endproperty
  a_cl: assert property (p_cl) else $error("closed accepted");
  property p_mc;
    rxv && m.protocol == SMC_PROTO_UDP && !m.mac_filter_enable && rx_in.group_dest |=> rx_drop;
  endproperty
  a_mc: assert property (p_mc) else $error("group without multicast");
  property p_bc;
    rxv && m.broadcast_block && rx_in.broadcast && (m.protocol == SMC_PROTO_UDP || m.protocol == SMC_PROTO_RAW)
      |=> rx_drop;
  endproperty
  a_bc: assert property (p_bc) else $error("broadcast passed");
  property p_v6; rxv && m.protocol == SMC_PROTO_RAW && m.single_dest_block && rx_in.ipv6 |=> rx_drop; endproperty
  a_v6: assert property (p_v6) else $error("ipv6 passed");
  property p_uc;
    rxv && m.protocol == SMC_PROTO_UDP && m.mac_filter_enable && m.single_dest_block
      && !rx_in.broadcast && !rx_in.group_dest |=> rx_drop;
  endproperty
  a_uc: assert property (p_uc) else $error("unicast passed");
  property p_all; rxv && m == smc_mode_type'({4'h0, SMC_PROTO_RAW}) |=> rx_accept; endproperty
  a_all: assert property (p_all) else $error("raw frame lost");
  property p_nd;
    clk_en && tcp_segment_rx[0] && socket_mode_reg[0].protocol == SMC_PROTO_TCP
      && socket_mode_reg[0].no_delayed_ack |=> ack_send[0];
  endproperty
  a_nd: assert property (p_nd) else $error("ack late");
endmodule : smc_socket_mode_properties

bind smc_socket_mode smc_socket_mode_properties smc_socket_mode_properties_inst (
  .clock, .rstn, .clk_en, .host_wr_en, .host_rd_en, .host_socket_index, .host_offset, .host_wdata,
  .host_rdata, .host_rvalid, .rx_in, .rx_accept, .rx_drop, .tcp_segment_rx, .ack_send, .socket_mode_reg);

// file: tb/smc_host_model.sv
// host model: register accesses and socket commands.
// assumes a read answers at the edge that takes it, half a cycle before the next falling edge.
`timescale 1ns/10ps
module smc_host_model (
  // clock
  input wire logic        clock,
  // register access
  output logic            host_wr_en,
  output logic            host_rd_en,
  output logic [2:0]      host_socket_index,
  output logic [15:0]     host_offset,
  output logic [7:0]      host_wdata,
  input wire logic [7:0]  host_rdata,
  input wire logic        host_rvalid,
  // commands
  output logic            cmd_open,
  output logic            cmd_close,
  output logic [2:0]      cmd_socket_index
);
  initial begin
    {host_wr_en, host_rd_en, host_socket_index, host_offset, host_wdata} = '0;
    {cmd_open, cmd_close, cmd_socket_index} = '0;
  end
  // released offset and data lines show the inverse, so a stale value never reads as good
  task automatic access(input logic w, input logic [2:0] s, input logic [15:0] o, input logic [7:0] d,
                        output logic [7:0] q, output logic v);
    @(negedge clock);
    host_wr_en = w;
    host_rd_en = !w;
    host_socket_index = s;
    host_offset = o;
    host_wdata = d;
    @(negedge clock);
    q = host_rdata;
    v = host_rvalid;
    host_wr_en = 1'b0;
    host_rd_en = 1'b0;
    host_offset = ~o;
    host_wdata = ~d;
  endtask : access
  // pulses open or close on one socket for one cycle
  task automatic command(input logic op, input logic [2:0] s);
    @(negedge clock);
    cmd_open = op;
    cmd_close = !op;
    cmd_socket_index = s;
    @(negedge clock);
    cmd_open = 1'b0;
    cmd_close = 1'b0;
  endtask : command
endmodule : smc_host_model

// file: tb/smc_socket_mode_test.sv
// self-checking bench for the socket mode block.
// assumes the host model and this bench both drive at the falling edge.
`timescale 1ns/10ps
module smc_socket_mode_test;
  import smc_pkg::*;
  localparam int TICK = 4;
  logic clock, rstn, clk_en, host_wr_en, host_rd_en, host_rvalid, cmd_open, cmd_close, rx_accept, rx_drop, v;
  logic [2:0] host_socket_index, cmd_socket_index, rx_socket_index, s;
  logic [15:0] host_offset, retry_time_value;
  logic [7:0] host_wdata, host_rdata, tcp_segment_rx, ack_send, igmp_version_select, q;
  logic [12:0] r;
  smc_rx_type rx_in;
  smc_mode_type [7:0] socket_mode_reg;
  int n_errors = 0, tests_run = 0, n;
  // mode, flags {broadcast, group, own mac, ipv6}, accepted
  logic [12:0] rows [16] = '{{8'h00, 4'h0, 1'b0}, {8'h01, 4'h0, 1'b1}, {8'h01, 4'h8, 1'b0},
    {8'h02, 4'h0, 1'b1}, {8'h42, 4'h8, 1'b0}, {8'h02, 4'h4, 1'b0}, {8'h82, 4'h4, 1'b1},
    {8'h92, 4'h0, 1'b0}, {8'h82, 4'h0, 1'b1}, {8'h84, 4'h0, 1'b0}, {8'h84, 4'h2, 1'b1},
    {8'h84, 4'h8, 1'b1}, {8'h04, 4'h0, 1'b1}, {8'h44, 4'h8, 1'b0}, {8'h24, 4'h4, 1'b0}, {8'h14, 4'h1, 1'b0}};
  logic [7:0] codes [4] = '{8'h01, 8'h02, 8'h04, 8'h00};
  logic [7:0] states [4] = '{8'h13, 8'h22, 8'h42, 8'h42};

  smc_socket_mode #(.RETRY_TICK_CYCLES(TICK)) smc_socket_mode_inst (.clock, .rstn, .clk_en, .host_wr_en,
    .host_rd_en, .host_socket_index, .host_offset, .host_wdata, .host_rdata, .host_rvalid, .cmd_open,
    .cmd_close, .cmd_socket_index, .rx_in, .rx_accept, .rx_drop, .rx_socket_index, .tcp_segment_rx,
    .retry_time_value, .ack_send, .igmp_version_select, .socket_mode_reg);
  smc_host_model smc_host_model_inst (.clock, .host_wr_en, .host_rd_en, .host_socket_index, .host_offset,
    .host_wdata, .host_rdata, .host_rvalid, .cmd_open, .cmd_close, .cmd_socket_index);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] si, input logic [15:0] o, input logic [7:0] d);
    smc_host_model_inst.access(1'b1, si, o, d, q, v);
  endtask : wr

  task automatic rd_chk(input logic [2:0] si, input logic [15:0] o, input logic [7:0] e);
    smc_host_model_inst.access(1'b0, si, o, 8'h00, q, v);
    chk(8'(v), 8'h01, "read answer");
    chk(q, e, "read data");
  endtask : rd_chk

  task automatic pulse_rx(input logic [2:0] si, input logic [3:0] f);
    @(negedge clock);
    rx_in = {1'b1, si, f};
    @(negedge clock);
    rx_in = '0;
  endtask : pulse_rx

  task automatic segment();
    @(negedge clock);
    tcp_segment_rx = 8'h01;
    @(negedge clock);
    tcp_segment_rx = 8'h00;
  endtask : segment

  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    complete_run();
  end

  initial begin
    {rstn, rx_in, tcp_segment_rx} = '0;
    clk_en = 1'b1;
    retry_time_value = 16'h0003;
    repeat (20) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    for (int i = 0; i < 16; i++) begin
      r = rows[i];
      s = (r[8:5] == SMC_PROTO_RAW) ? 3'h0 : 3'(i);
      wr(s, SMC_MODE_OFFSET, r[12:5]);
      pulse_rx(s, r[4:1]);
      chk(8'(rx_accept), 8'(r[0]), "accept");
      chk(8'(rx_socket_index), 8'(s), "rx socket");
      chk(8'(rx_drop), 8'(!r[0]), "drop");
    end
    $display("test receive done");
    for (int i = 0; i < 8; i++) wr(3'(i), SMC_MODE_OFFSET, {1'b1, 3'(i), 4'h2});
    for (int i = 0; i < 8; i++) rd_chk(3'(i), SMC_MODE_OFFSET, {1'b1, 3'(i), 4'h2});
    chk(igmp_version_select, 8'hCC, "igmp select");
    wr(3'h1, 16'h0001, 8'hFF);
    rd_chk(3'h1, SMC_MODE_OFFSET, 8'h92);
    rd_chk(3'h1, 16'h0005, SMC_UNMAPPED_READ);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      wr(3'h0, SMC_MODE_OFFSET, codes[k]);
      smc_host_model_inst.command(1'b1, 3'h0);
      rd_chk(3'h0, SMC_STATE_OFFSET, states[k]);
    end
    // close brings the socket state back to its reset value
    smc_host_model_inst.command(1'b0, 3'h0);
    rd_chk(3'h0, SMC_STATE_OFFSET, SMC_STATE_RESET);
    $display("test open done");
    wr(3'h0, SMC_MODE_OFFSET, 8'h21);
    segment();
    chk(8'(ack_send[0]), 8'h01, "immediate ack");
    wr(3'h0, SMC_MODE_OFFSET, 8'h01);
    segment();
    n = 0;
    while (ack_send[0] !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk(8'(n >= 3 * TICK && n <= 4 * TICK + 2), 8'h01, "delayed ack");
    $display("test ack done");
    @(negedge clock);
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    for (int i = 0; i < 8; i++) rd_chk(3'(i), SMC_MODE_OFFSET, SMC_MODE_RESET);
    // a write offered while the clock enable is low must leave no trace
    clk_en = 1'b0;
    wr(3'h2, SMC_MODE_OFFSET, 8'h55);
    clk_en = 1'b1;
    rd_chk(3'h2, SMC_MODE_OFFSET, SMC_MODE_RESET);
    $display("test reset done");
    complete_run();
  end
endmodule : smc_socket_mode_test
